// *** core/rsd_ring.sv ***
/*
  Receive slave-DMA ring engine: moves accepted frames from on-chip frame RAM
  to a host ring through one ISA DMA request/acknowledge pair.
  Assumes a frame RAM that presents one accepted frame at a time and steps its
  word on a pop pulse, and a host DMA controller that drives acknowledge low.
*/
`timescale 1ns/1ns
module rsd_ring #(
  parameter int BURST_ON = rsd_pkg::BURST_ON_CYC,
  parameter int BURST_OFF = rsd_pkg::BURST_OFF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  // Configuration bits
  input wire logic rxDmaExclusiveEn,
  input wire logic autoSwitchDmaEn,
  input wire logic dmaRingSizeSel,
  input wire logic dmaBurstPacingEn,
  input wire logic dmaRingReset,
  input wire logic dmaFrameIrqEn,
  input wire logic streamModeEn,
  input wire logic streamCycleEnd,
  input wire logic bufEventRead,
  // Receive event view
  input wire logic [15:0] rxEventIn,
  output logic [15:0] rxEventView,
  // Frame RAM side
  input wire logic frameValid,
  input wire logic [15:0] frameStatus,
  input wire logic [15:0] frameLength,
  input wire logic [15:0] frameData,
  input wire logic frameLost,
  output logic frameWordPop,
  output logic frameRelease,
  output logic dmaActive,
  // ISA DMA pins
  output logic [2:0] dmaReqPin,
  input wire logic [2:0] dmaAckPinN,
  output logic [15:0] dmaData,
  // Status
  output logic dmaFrameReadyFlag,
  output logic dmaFrameIrq,
  output logic [rsd_pkg::MISS_W-1:0] missedFrameCounter
);

  // Three-stage acknowledge synchronisers
  logic [2:0] ackS1;
  logic [2:0] ackS2;
  logic [2:0] ackS3;
  logic [2:0] ackStable;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gAckSync
      always_ff @(posedge mclk) begin
        if (srst) begin
          ackS1[gi] <= 1'b1;
          ackS2[gi] <= 1'b1;
          ackS3[gi] <= 1'b1;
          ackStable[gi] <= 1'b1;
        end else begin
          ackS1[gi] <= dmaAckPinN[gi];
          ackS2[gi] <= ackS1[gi];
          ackS3[gi] <= ackS2[gi];
          if (ackS2[gi] == ackS3[gi]) begin
            ackStable[gi] <= ackS3[gi];
          end
        end
      end
    end
  endgenerate

  // Byte footprint of a frame in the ring, rounded to a double word
  function automatic logic [16:0] ringFoot(input logic [15:0] len);
    ringFoot = ({1'b0, len} + rsd_pkg::HDR_BYTES + rsd_pkg::ALIGN_PAD) & rsd_pkg::ALIGN_MASK;
  endfunction : ringFoot

  // Engine state
  rsd_pkg::rsd_state_e state, next_state;
  logic [1:0] chanSel, next_chanSel;
  logic [15:0] wrPtr, next_wrPtr;
  logic [15:0] frameStart, next_frameStart;
  logic [15:0] batchBase, next_batchBase;
  logic [15:0] commitLo, next_commitLo;
  logic commitActive, next_commitActive;
  logic [15:0] startOffset, next_startOffset;
  logic [rsd_pkg::FCNT_W-1:0] frameCount, next_frameCount;
  logic [15:0] byteCount, next_byteCount;
  logic [15:0] wordsLeft, next_wordsLeft;
  logic [15:0] curLength, next_curLength;
  logic [31:0] burstCnt, next_burstCnt;
  logic burstOn, next_burstOn;
  logic ackLow, next_ackLow;
  logic [rsd_pkg::MISS_W-1:0] next_missedFrameCounter;
  logic next_dmaFrameReadyFlag;
  logic [2:0] next_dmaReqPin;
  logic [15:0] next_dmaData;
  logic next_frameWordPop;
  logic next_frameRelease;
  logic [15:0] next_regRdData;

  // Decoded helpers
  logic [15:0] ringMask;
  logic dmaOn;
  logic ackNow;
  logic wordTaken;
  logic fcntRead;
  logic bcntRead;
  logic [16:0] freeBytes;
  logic [16:0] footCur;
  logic spaceOk;

  assign ringMask = dmaRingSizeSel ? rsd_pkg::RING_MASK_64K : rsd_pkg::RING_MASK_16K; // RL7
  assign dmaOn = rxDmaExclusiveEn; // RL1 RL2
  assign ackNow = (chanSel <= rsd_pkg::CHAN_MAX) ? !ackStable[chanSel] : 1'b0; // RL9
  assign wordTaken = ackNow && !ackLow;
  assign fcntRead = regRd && (regAddr == rsd_pkg::ADDR_FCNT);
  assign bcntRead = regRd && (regAddr == rsd_pkg::ADDR_BCNT);
  assign freeBytes = {1'b0, (commitLo - wrPtr) & ringMask};
  assign footCur = ringFoot(curLength); // RL18
  assign spaceOk = !commitActive || ((freeBytes != 17'h00000) && (ringFoot(frameLength) <= freeBytes)); // RL16

  // Next-state logic for the transfer, ring and counters
  always_comb begin
    next_state = state;
    next_chanSel = chanSel;
    next_wrPtr = wrPtr;
    next_frameStart = frameStart;
    next_batchBase = batchBase;
    next_commitLo = commitLo;
    next_commitActive = commitActive;
    next_startOffset = startOffset;
    next_frameCount = fcntRead ? '0 : frameCount; // RL22
    next_byteCount = bcntRead ? 16'h0000 : byteCount; // RL22
    next_wordsLeft = wordsLeft;
    next_curLength = curLength;
    next_burstCnt = burstCnt;
    next_burstOn = burstOn;
    next_ackLow = ackNow;
    next_missedFrameCounter = missedFrameCounter + (frameLost ? 1'b1 : 1'b0); // RL14
    next_dmaData = dmaData;
    next_frameWordPop = 1'b0;
    next_frameRelease = 1'b0;
    // Channel select accepts only legal pair numbers
    if (regWr && (regAddr == rsd_pkg::ADDR_CHAN) && (regWrData[1:0] <= rsd_pkg::CHAN_MAX) &&
        (regWrData[15:2] == 14'h0000)) begin
      next_chanSel = regWrData[1:0]; // RL3
    end
    // Commit the batch on a frame-count read, freeing the previous one
    if (fcntRead) begin
      next_commitActive = (frameCount != '0); // RL16 RL17 RL21
      if (frameCount != '0) begin
        next_commitLo = batchBase;
        next_batchBase = wrPtr;
      end
    end else if (bufEventRead && dmaFrameReadyFlag && (frameCount != '0)) begin
      next_commitActive = 1'b0; // RL17
    end
    // Transfer sequence
    unique case (state)
      rsd_pkg::ST_IDLE: begin
        if (dmaOn && frameValid && spaceOk) begin // RL8 RL16
          next_state = rsd_pkg::ST_STATUS;
          next_frameStart = wrPtr; // RL18
          next_curLength = frameLength;
          next_wordsLeft = (frameLength + 16'h0001) >> 1;
          next_dmaData = frameStatus; // RL10
          next_burstCnt = 32'h0000_0000;
          next_burstOn = 1'b1;
        end
      end
      rsd_pkg::ST_STATUS: begin
        if (wordTaken) begin
          next_state = rsd_pkg::ST_LENGTH;
          next_dmaData = curLength; // RL10
        end
      end
      rsd_pkg::ST_LENGTH: begin
        if (wordTaken) begin
          next_state = (wordsLeft == 16'h0000) ? rsd_pkg::ST_DONE : rsd_pkg::ST_DATA;
          next_dmaData = frameData; // RL10 RL18
        end
      end
      rsd_pkg::ST_DATA: begin
        if (wordTaken) begin
          next_frameWordPop = 1'b1;
          next_wordsLeft = wordsLeft - 16'h0001;
          if (wordsLeft == 16'h0001) begin
            next_state = rsd_pkg::ST_DONE;
          end
        end else begin
          next_dmaData = frameData;
        end
      end
      rsd_pkg::ST_DONE: begin
        next_state = rsd_pkg::ST_IDLE;
        next_startOffset = frameStart & ringMask; // RL4 RL7 RL12
        next_frameCount = next_frameCount + 1'b1; // RL5 RL12
        next_byteCount = next_byteCount + curLength + rsd_pkg::HDR_BYTES[15:0]; // RL6 RL12
        next_wrPtr = (wrPtr + footCur[15:0]) & ringMask; // RL18
        next_frameRelease = 1'b1; // RL12
      end
    endcase
    // Burst pacing of the request
    if (state != rsd_pkg::ST_IDLE) begin
      next_burstCnt = burstCnt + 32'h0000_0001;
      if (burstOn && (burstCnt >= 32'(BURST_ON - 1))) begin
        next_burstOn = 1'b0; // RL11
        next_burstCnt = 32'h0000_0000;
      end else if (!burstOn && (burstCnt >= 32'(BURST_OFF - 1))) begin
        next_burstOn = 1'b1; // RL11
        next_burstCnt = 32'h0000_0000;
      end
    end
    // Ring reset frees everything
    if (dmaRingReset) begin
      next_commitActive = 1'b0; // RL17
      next_wrPtr = 16'h0000;
      next_batchBase = 16'h0000;
      next_commitLo = 16'h0000;
    end
  end

  // Flag, request pins and register read data
  always_comb begin
    next_dmaFrameReadyFlag = dmaFrameReadyFlag;
    if (next_frameCount == '0) begin
      next_dmaFrameReadyFlag = 1'b0; // RL20
    end else if (streamModeEn) begin
      next_dmaFrameReadyFlag = dmaFrameReadyFlag || streamCycleEnd; // RL20
    end else begin
      next_dmaFrameReadyFlag = 1'b1; // RL19
    end
    next_dmaReqPin = 3'h0;
    if ((next_state == rsd_pkg::ST_STATUS) || (next_state == rsd_pkg::ST_LENGTH) ||
        (next_state == rsd_pkg::ST_DATA)) begin
      if ((next_chanSel <= rsd_pkg::CHAN_MAX) && (!dmaBurstPacingEn || next_burstOn)) begin
        next_dmaReqPin[next_chanSel] = 1'b1; // RL8 RL11
      end
    end
    next_regRdData = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        rsd_pkg::ADDR_CHAN: next_regRdData = {14'h0000, chanSel};
        rsd_pkg::ADDR_SOF: next_regRdData = startOffset;
        rsd_pkg::ADDR_FCNT: next_regRdData = {4'h0, frameCount}; // RL5
        rsd_pkg::ADDR_BCNT: next_regRdData = byteCount;
        default: next_regRdData = 16'h0000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= rsd_pkg::ST_IDLE;
      chanSel <= rsd_pkg::CHAN_RESET;
      wrPtr <= 16'h0000;
      frameStart <= 16'h0000;
      batchBase <= 16'h0000;
      commitLo <= 16'h0000;
      commitActive <= 1'b0;
      startOffset <= 16'h0000;
      frameCount <= '0;
      byteCount <= 16'h0000;
      wordsLeft <= 16'h0000;
      curLength <= 16'h0000;
      burstCnt <= 32'h0000_0000;
      burstOn <= 1'b1;
      ackLow <= 1'b0;
      missedFrameCounter <= '0;
      dmaFrameReadyFlag <= 1'b0;
      dmaFrameIrq <= 1'b0;
      dmaReqPin <= 3'h0;
      dmaData <= 16'h0000;
      frameWordPop <= 1'b0;
      frameRelease <= 1'b0;
      dmaActive <= 1'b0;
      regRdData <= 16'h0000;
      rxEventView <= 16'h0000;
    end else begin
      state <= next_state;
      chanSel <= next_chanSel;
      wrPtr <= next_wrPtr;
      frameStart <= next_frameStart;
      batchBase <= next_batchBase;
      commitLo <= next_commitLo;
      commitActive <= next_commitActive;
      startOffset <= next_startOffset;
      frameCount <= next_frameCount;
      byteCount <= next_byteCount;
      wordsLeft <= next_wordsLeft;
      curLength <= next_curLength;
      burstCnt <= next_burstCnt;
      burstOn <= next_burstOn;
      ackLow <= next_ackLow;
      missedFrameCounter <= next_missedFrameCounter;
      dmaFrameReadyFlag <= next_dmaFrameReadyFlag;
      dmaFrameIrq <= next_dmaFrameReadyFlag && dmaFrameIrqEn; // RL13
      dmaReqPin <= next_dmaReqPin;
      dmaData <= next_dmaData;
      frameWordPop <= next_frameWordPop;
      frameRelease <= next_frameRelease;
      dmaActive <= dmaOn || (autoSwitchDmaEn && 1'b0); // RL2
      regRdData <= next_regRdData;
      rxEventView <= dmaOn ? 16'h0000 : rxEventIn; // RL15
    end
  end

endmodule : rsd_ring

// *** core/rsd_pkg.sv ***
/*
  Constants, types and register layout for the receive slave-DMA ring engine.
  Assumes a 100 MHz system clock and a 16-bit register port addressed by the
  printed register offsets.
*/
// Notes on behaviour
// [RL1] Exclusive receive-DMA enable moves every accepted frame
// [RL2] Exclusive enable wins over auto-switch enable
// [RL3] Channel select 0..2 picks request/acknowledge pair
// [RL4] Start-of-frame holds offset of latest frame
// [RL5] Frame count: low 12 bits, upper reserved
// [RL6] Byte count reports bytes moved since read
// [RL7] Ring size bit: 16K clear, 64K set
// [RL8] Request only after whole frame is accepted
// [RL9] Host grants by driving acknowledge low
// [RL10] Status word, length word, then data bytes
// [RL11] Burst bit paces request 28 ms / 1.3 ms
// [RL12] Completion updates registers, flag, releases buffer
// [RL13] Interrupt only when frame interrupt enabled
// [RL14] Lost frames increment the missed-frame counter
// [RL15] Receive event reads zero while DMA active
// [RL16] Committed space is never overwritten
// [RL17] Reread, implied skip or ring reset frees
// [RL18] 16-bit words, frames on 32-bit boundaries
// [RL19] Flag set when count non-zero, read-proof
// [RL20] Streaming sets at cycle end; zero count clears
// [RL21] Host reads frame count to learn frames
// [RL22] Count accumulations restart after each read
package rsd_pkg;
  // Register offsets
  localparam logic [15:0] ADDR_CHAN = 16'h0024;
  localparam logic [15:0] ADDR_SOF = 16'h0026;
  localparam logic [15:0] ADDR_FCNT = 16'h0028;
  localparam logic [15:0] ADDR_BCNT = 16'h002a;
  // Field layout and reset values
  localparam int FCNT_W = 12;
  localparam int MISS_W = 10;
  localparam logic [1:0] CHAN_MAX = 2'h2;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [15:0] RING_MASK_16K = 16'h3fff;
  localparam logic [15:0] RING_MASK_64K = 16'hffff;
  localparam logic [16:0] HDR_BYTES = 17'h00004;
  localparam logic [16:0] ALIGN_PAD = 17'h00003;
  localparam logic [16:0] ALIGN_MASK = 17'h1fffc;
  // Burst pacing times and cycle counts
  localparam int CLK_MHZ = 100;
  localparam int BURST_ON_US = 28000;
  localparam int BURST_OFF_US = 1300;
  localparam int BURST_ON_CYC = BURST_ON_US * CLK_MHZ;
  localparam int BURST_OFF_CYC = BURST_OFF_US * CLK_MHZ;
  // Transfer sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STATUS,
    ST_LENGTH,
    ST_DATA,
    ST_DONE
  } rsd_state_e;
endpackage : rsd_pkg

// *** tb/rsd_ring_asserts.sv ***
/* Checker for the slave-DMA ring engine.
   Assumes it is bound to rsd_ring and sees only its ports. */
`timescale 1ns/1ns
module rsd_ring_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Watched inputs
  input wire logic [15:0] regAddr,
  input wire logic regRd,
  input wire logic rxDmaExclusiveEn,
  input wire logic dmaFrameIrqEn,
  input wire logic streamCycleEnd,
  input wire logic frameValid,
  input wire logic frameLost,
  // Watched outputs
  input wire logic [15:0] regRdData,
  input wire logic [15:0] rxEventView,
  input wire logic frameRelease,
  input wire logic [2:0] dmaReqPin,
  input wire logic dmaFrameReadyFlag,
  input wire logic dmaFrameIrq,
  input wire logic [rsd_pkg::MISS_W-1:0] missedFrameCounter
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Request pins
  a_req_one_hot: assert property ($onehot0(dmaReqPin))
    else $error("two request pins high");
  a_req_after_frame: assert property ($rose(|dmaReqPin) |-> $past(frameValid) && $past(rxDmaExclusiveEn))
    else $error("request without accepted frame");
  a_release_drops_req: assert property (frameRelease |-> dmaReqPin == 3'h0 ##1 !frameRelease)
    else $error("request past frame end");
  // Register and status views
  a_fcnt_upper_zero: assert property ($past(regRd) && $past(regAddr) == rsd_pkg::ADDR_FCNT |->
    regRdData[15:12] == 4'h0)
    else $error("frame count upper bits set");
  a_event_hidden: assert property ($past(rxDmaExclusiveEn, 2) && $past(rxDmaExclusiveEn) |->
    rxEventView == 16'h0)
    else $error("event view not zero");
  a_irq_gated: assert property (dmaFrameIrq == (dmaFrameReadyFlag && $past(dmaFrameIrqEn)))
    else $error("irq not flag and enable");
  a_miss_step: assert property (missedFrameCounter == $past(missedFrameCounter) + $past(frameLost))
    else $error("missed counter step wrong");
  a_flag_cause: assert property ($rose(dmaFrameReadyFlag) |-> frameRelease || $past(streamCycleEnd))
    else $error("flag set without completion");
endmodule : rsd_ring_asserts

bind rsd_ring rsd_ring_asserts u_chk (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regRd(regRd),
  .rxDmaExclusiveEn(rxDmaExclusiveEn), .dmaFrameIrqEn(dmaFrameIrqEn), .streamCycleEnd(streamCycleEnd),
  .frameValid(frameValid), .frameLost(frameLost), .regRdData(regRdData), .rxEventView(rxEventView),
  .frameRelease(frameRelease), .dmaReqPin(dmaReqPin), .dmaFrameReadyFlag(dmaFrameReadyFlag),
  .dmaFrameIrq(dmaFrameIrq), .missedFrameCounter(missedFrameCounter));

// *** tb/rsd_host_dma.sv ***
/* Host DMA controller model for one request/acknowledge pair.
   Assumes the engine holds its word until the acknowledge is seen. */
`timescale 1ns/1ns
module rsd_host_dma (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Engine side, and the bench's slow-host gap setting
  input wire logic req,
  input wire logic [15:0] data,
  input wire logic [3:0] slowGap,
  // Acknowledge, active low
  output logic ackN
);
  logic [15:0] seen[$];
  logic [4:0] cnt;
  // Grant only a pending request, one word per low pulse
  always @(posedge mclk) begin
    if (srst) begin
      ackN <= 1'b1;
      cnt <= 5'h0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
      if (cnt == {1'b0, slowGap} + 5'h4)
        ackN <= 1'b1;
    end else if (req) begin
      ackN <= 1'b0;
      seen.push_back(data);
      cnt <= {1'b0, slowGap} + 5'h8;
    end
  end
endmodule : rsd_host_dma

// *** tb/tb_top.sv ***
/* Bench for the slave-DMA ring engine with a host DMA model.
   Assumes short burst pacing counts. */
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] regAddr = 16'h0, regWrData = 16'h0, rxEventIn = 16'h0, frameStatus = 16'h0, frameLength = 16'h0;
  logic regRd = 1'b0, regWr = 1'b0, rxDmaExclusiveEn = 1'b1, autoSwitchDmaEn = 1'b1, dmaBurstPacingEn = 1'b0;
  logic dmaRingReset = 1'b0, streamModeEn = 1'b0, streamCycleEnd = 1'b0, dmaActive;
  logic dmaFrameIrqEn = 1'b1, frameValid = 1'b0, frameLost = 1'b0, ackN;
  logic [15:0] regRdData, rxEventView, dmaData, frameData;
  logic [2:0] dmaReqPin, dmaAckPinN;
  logic frameWordPop, frameRelease, dmaFrameReadyFlag, dmaFrameIrq;
  logic [rsd_pkg::MISS_W-1:0] missedFrameCounter;
  logic [1:0] chan = 2'h0;
  logic [3:0] slowGap = 4'h0;
  logic [7:0] widx = 8'h0;
  int fail_count = 0;
  int num_checks = 0;
  // Clock, frame RAM stand-in and acknowledge steering
  always #5 mclk = ~mclk;
  always @(negedge mclk) if (frameWordPop) widx <= widx + 8'h1;
  assign frameData = 16'ha500 + {8'h0, widx};
  assign dmaAckPinN = ~(3'h1 << chan) | {3{ackN}};
  rsd_ring #(.BURST_ON(20), .BURST_OFF(5)) u_dut (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .rxDmaExclusiveEn(rxDmaExclusiveEn),
    .autoSwitchDmaEn(autoSwitchDmaEn), .dmaRingSizeSel(1'b0), .dmaBurstPacingEn(dmaBurstPacingEn),
    .dmaRingReset(dmaRingReset), .dmaFrameIrqEn(dmaFrameIrqEn), .streamModeEn(streamModeEn),
    .streamCycleEnd(streamCycleEnd),
    .bufEventRead(1'b0), .rxEventIn(rxEventIn), .rxEventView(rxEventView), .frameValid(frameValid),
    .frameStatus(frameStatus), .frameLength(frameLength), .frameData(frameData), .frameLost(frameLost),
    .frameWordPop(frameWordPop), .frameRelease(frameRelease), .dmaActive(dmaActive), .dmaReqPin(dmaReqPin),
    .dmaAckPinN(dmaAckPinN), .dmaData(dmaData), .dmaFrameReadyFlag(dmaFrameReadyFlag),
    .dmaFrameIrq(dmaFrameIrq), .missedFrameCounter(missedFrameCounter));
  rsd_host_dma u_host (.mclk(mclk), .srst(srst), .req(dmaReqPin[chan]), .data(dmaData), .slowGap(slowGap),
    .ackN(ackN));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic reg_wr(input logic [15:0] addr, input logic [15:0] val);
    @(negedge mclk);
    regAddr = addr;
    regWrData = val;
    regWr = 1'b1;
    @(negedge mclk);
    regWr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] addr, output logic [15:0] val);
    @(negedge mclk);
    regAddr = addr;
    regRd = 1'b1;
    @(negedge mclk);
    regRd = 1'b0;
    val = regRdData;
  endtask : reg_rd

  // Offer one frame, count pacing gaps, compare what the host received
  task automatic send_frame(input logic [15:0] len, output int gaps);
    int n;
    int words;
    gaps = 0;
    words = int'(len / 16'h2 + len % 16'h2 + 16'h2);
    u_host.seen.delete();
    @(negedge mclk);
    widx = 8'h0;
    frameStatus = 16'h0100 + len;
    frameLength = len;
    frameValid = 1'b1;
    for (n = 0; n < 4000 && frameRelease !== 1'b1; n++) begin
      @(negedge mclk);
      if (n > 2 && dmaReqPin[chan] !== 1'b1 && frameRelease !== 1'b1 && u_host.seen.size() < words)
        gaps++;
    end
    frameValid = 1'b0;
    if (n == 4000) begin
      fail_count++;
      print_verdict();
    end
    check("word count", 16'(u_host.seen.size()), len / 16'h2 + len % 16'h2 + 16'h2);
    foreach (u_host.seen[i])
      check("ring word", u_host.seen[i], i == 0 ? frameStatus : i == 1 ? len : 16'ha500 + 16'(i - 2));
  endtask : send_frame

  // Main sequence
  initial begin
    logic [15:0] v, sof, nxt, bytes;
    logic [15:0] lens[3] = '{16'h5, 16'h9, 16'h20};
    logic [15:0] addrs[5] = '{rsd_pkg::ADDR_CHAN, rsd_pkg::ADDR_SOF, rsd_pkg::ADDR_FCNT, rsd_pkg::ADDR_BCNT, 16'h2c};
    int gaps;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    foreach (addrs[i]) begin
      reg_rd(addrs[i], v);
      check("reset read", v, 16'h0);
    end
    check("dma active", 16'(dmaActive), 16'h1);
    reg_wr(rsd_pkg::ADDR_CHAN, 16'h3);
    reg_rd(rsd_pkg::ADDR_CHAN, v);
    check("channel", v, 16'h0);
    rxEventIn = 16'h1234;
    repeat (3) @(negedge mclk);
    check("event view", rxEventView, 16'h0);
    // One frame per channel: plain, slow host, paced bursts
    nxt = 16'h0;
    bytes = 16'h0;
    foreach (lens[i]) begin
      reg_wr(rsd_pkg::ADDR_CHAN, 16'(i));
      chan = 2'(i);
      slowGap = (i == 1) ? 4'h3 : 4'h0;
      dmaBurstPacingEn = (i == 2);
      dmaFrameIrqEn = (i != 2);
      autoSwitchDmaEn = (i != 1);
      reg_rd(rsd_pkg::ADDR_CHAN, v);
      check("channel", v, 16'(i));
      send_frame(lens[i], gaps);
      check("pacing gaps", 16'(gaps != 0), 16'(i == 2));
      sof = nxt;
      nxt = (nxt + lens[i] + 16'h7) & 16'hfffc;
      bytes = bytes + lens[i] + 16'h4;
      repeat (3) @(negedge mclk);
      check("ready flag", 16'(dmaFrameReadyFlag), 16'h1);
      check("frame irq", 16'(dmaFrameIrq), 16'(i != 2));
    end
    reg_rd(rsd_pkg::ADDR_SOF, v);
    check("start offset", v, sof);
    reg_rd(rsd_pkg::ADDR_FCNT, v);
    check("frame count", v, 16'h3);
    reg_rd(rsd_pkg::ADDR_BCNT, v);
    check("byte count", v, bytes);
    reg_rd(rsd_pkg::ADDR_FCNT, v);
    check("frame count", v, 16'h0);
    reg_rd(rsd_pkg::ADDR_BCNT, v);
    check("byte count", v, 16'h0);
    repeat (2) @(negedge mclk);
    check("ready flag", 16'(dmaFrameReadyFlag), 16'h0);
    // Ring reset rewinds the ring; stream mode holds the flag until the cycle end
    dmaRingReset = 1'b1;
    streamModeEn = 1'b1;
    @(negedge mclk);
    dmaRingReset = 1'b0;
    send_frame(16'h4, gaps);
    repeat (3) @(negedge mclk);
    check("stream flag", 16'(dmaFrameReadyFlag), 16'h0);
    streamCycleEnd = 1'b1;
    @(negedge mclk);
    streamCycleEnd = 1'b0;
    @(negedge mclk);
    check("stream flag", 16'(dmaFrameReadyFlag), 16'h1);
    reg_rd(rsd_pkg::ADDR_SOF, v);
    check("start offset", v, 16'h0);
    // No request without the exclusive enable
    rxDmaExclusiveEn = 1'b0;
    frameValid = 1'b1;
    v = 16'h0;
    repeat (40) begin
      @(negedge mclk);
      v = v | 16'(dmaReqPin);
    end
    check("request", v, 16'h0);
    check("dma active", 16'(dmaActive), 16'h0);
    check("event view", rxEventView, 16'h1234);
    frameValid = 1'b0;
    frameLost = 1'b1;
    @(negedge mclk);
    frameLost = 1'b0;
    @(negedge mclk);
    check("missed count", 16'(missedFrameCounter), 16'h1);
    print_verdict();
  end
endmodule : tb_top
